// *** core/tsc_lamp_logic.sv ***
`include "tsc_params.svh"
module tsc_lamp_logic
  import tsc_pkg::*;
(
  input  wire logic           pclk,
  input  wire logic           presetn,
  input  wire tsc_switch_type sw,
  input  wire logic           fast_modulation_bit,
  input  wire logic           slow_blink_bit,
  output tsc_lamp_type        lamps
);
  // =====================================================================
  // lamp equations
  // lets both turn inputs be treated independently
  wire logic dim        = sw.parking & fast_modulation_bit;
  wire logic left_sel   = (sw.left_turn | sw.emergency) & slow_blink_bit;
  wire logic right_sel  = (sw.right_turn | sw.emergency) & slow_blink_bit;
  wire logic left_brk   = sw.brake & ~sw.left_turn;
  wire logic right_brk  = sw.brake & ~sw.right_turn;
  tsc_lamp_type lamps_next;

  assign lamps_next.left_dash   = left_sel;
  assign lamps_next.right_dash  = right_sel;
  assign lamps_next.left_front  = left_sel | dim;
  assign lamps_next.right_front = right_sel | dim;
  assign lamps_next.left_rear   = left_brk | left_sel | dim;
  assign lamps_next.right_rear  = right_brk | right_sel | dim;

  // registered lamps, refreshed every clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lamps <= '0;
    end else begin
      lamps <= lamps_next;
    end
  end
endmodule

// *** core/tsc_top.sv ***
`include "tsc_params.svh"
module tsc_top
  import tsc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        left_turn_in,
  input  wire logic        right_turn_in,
  input  wire logic        brake_in,
  input  wire logic        emergency_in,
  input  wire logic        parking_in,
  output tsc_lamp_type     lamps,
  output logic             irq
);
  localparam int MC_CYC = `TSC_CYC_PER_MC;

  // =====================================================================
  // pin synchronisers
  tsc_switch_type sw_meta_reg;
  tsc_switch_type sw_sync_reg;
  wire tsc_switch_type sw_pins = '{left_turn_in, right_turn_in, brake_in,
                                  emergency_in, parking_in};

  // two flops before any logic sees the switches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_meta_reg <= '0;
      sw_sync_reg <= '0;
    end else begin
      sw_meta_reg <= sw_pins;
      sw_sync_reg <= sw_meta_reg;
    end
  end

  // =====================================================================
  // register state
  logic [7:0] ctrl_reg;
  logic [1:0] irq_stat_reg;
  logic [1:0] irq_mask_reg;
  logic [7:0] timer_low_byte;
  logic [7:0] timer_high_byte;
  logic [7:0] subdiv_reg;
  logic [4:0] mc_cnt_reg;

  wire logic       timer_run_bit      = ctrl_reg[`TSC_CTRL_RUN_BIT];
  wire logic       timer_event_enable = ctrl_reg[`TSC_CTRL_TEV_BIT];
  wire logic       global_event_enable = ctrl_reg[`TSC_CTRL_GEV_BIT];
  wire logic [1:0] timer_mode_setting = ctrl_reg[`TSC_CTRL_MODE_LSB +: 2];

  // =====================================================================
  // apb decode
  wire logic acc      = psel & penable;
  wire logic wr_en    = acc & pwrite;
  wire logic rd_en    = acc & ~pwrite;
  wire logic hit_ctrl = paddr == `TSC_CTRL_ADDR;
  wire logic hit_stat = paddr == `TSC_STATUS_ADDR;
  wire logic hit_irqs = paddr == `TSC_IRQ_STAT_ADDR;
  wire logic hit_mask = paddr == `TSC_IRQ_MASK_ADDR;
  wire logic hit_tmr  = paddr == `TSC_TIMER_ADDR;
  wire logic hit_sub  = paddr == `TSC_SUBDIV_ADDR;
  wire logic hit_any  = hit_ctrl | hit_stat | hit_irqs | hit_mask | hit_tmr | hit_sub;

  assign pready  = 1'b1;
  assign pslverr = acc & ~hit_any;

  // =====================================================================
  // timer datapath
  wire logic mc_tick    = mc_cnt_reg == 5'(MC_CYC - 1);
  wire logic count_on   = timer_run_bit & (timer_mode_setting == `TSC_MODE_16BIT);
  wire logic step       = count_on & mc_tick;
  wire logic low_ovf    = step & (timer_low_byte == 8'hff);
  wire logic high_ovf   = low_ovf & (timer_high_byte == 8'hff);
  wire logic tick       = high_ovf & timer_event_enable & global_event_enable;
  wire logic sub_zero   = subdiv_reg == 8'h01;
  logic [7:0] subdiv_next;
  assign subdiv_next = sub_zero ? `TSC_SUBDIV_RELOAD : subdiv_reg - 8'h01;

  wire logic fast_modulation_bit = subdiv_reg[0];
  wire logic slow_blink_bit      = subdiv_reg[7];
  wire logic blink_rise          = tick & ~subdiv_reg[7] & subdiv_next[7];

  // machine cycle prescaler, 20 clocks per microsecond
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mc_cnt_reg <= '0;
    end else begin
      mc_cnt_reg <= (mc_tick | ~count_on) ? 5'h00 : mc_cnt_reg + 5'h01;
    end
  end

  // 16-bit timer with high byte reload on high byte overflow
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_low_byte  <= `TSC_TL_RESET;
      timer_high_byte <= `TSC_TH_RESET;
    end else if (wr_en & hit_tmr) begin
      timer_low_byte  <= pwdata[7:0];
      timer_high_byte <= pwdata[15:8];
    end else if (step) begin
      timer_low_byte <= timer_low_byte + 8'h01;
      if (high_ovf) begin
        timer_high_byte <= `TSC_TH_RELOAD;
      end else if (low_ovf) begin
        timer_high_byte <= timer_high_byte + 8'h01;
      end
    end
  end

  // subdivider of the tick rate
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      subdiv_reg <= `TSC_SUBDIV_RELOAD;
    end else if (wr_en & hit_sub) begin
      subdiv_reg <= pwdata[7:0];
    end else if (tick) begin
      subdiv_reg <= subdiv_next;
    end
  end

  // =====================================================================
  // control and interrupt registers
  wire logic [1:0] irq_events = {blink_rise, tick};
  wire logic [1:0] irq_clear  = (rd_en & hit_irqs) ? 2'h3 : 2'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg     <= `TSC_CTRL_RESET;
      irq_mask_reg <= `TSC_IRQ_RESET;
      irq_stat_reg <= `TSC_IRQ_RESET;
    end else begin
      if (wr_en & hit_ctrl) begin
        ctrl_reg <= pwdata[7:0];
      end
      if (wr_en & hit_mask) begin
        irq_mask_reg <= pwdata[1:0];
      end
      irq_stat_reg <= (irq_stat_reg & ~irq_clear) | irq_events; // set wins
    end
  end

  assign irq = |(irq_stat_reg & irq_mask_reg);

  // =====================================================================
  // read mux
  wire logic [31:0] status_word = {26'h0, lamps.left_dash, lamps.right_dash,
                                   sw_sync_reg[4:3], slow_blink_bit, fast_modulation_bit};
  logic [31:0] rd_mux;
  assign rd_mux = hit_ctrl ? {24'h0, ctrl_reg} :
                  hit_stat ? status_word :
                  hit_irqs ? {30'h0, irq_stat_reg} :
                  hit_mask ? {30'h0, irq_mask_reg} :
                  hit_tmr  ? {16'h0, timer_high_byte, timer_low_byte} :
                  hit_sub  ? {24'h0, subdiv_reg} : 32'h0;
  assign prdata = rd_en ? rd_mux : 32'h0;

  // =====================================================================
  // lamp logic
  tsc_lamp_logic u_lamp (
    .pclk                (pclk),
    .presetn             (presetn),
    .sw                  (sw_sync_reg),
    .fast_modulation_bit (fast_modulation_bit),
    .slow_blink_bit      (slow_blink_bit),
    .lamps               (lamps)
  );
endmodule

// *** dv/tsc_assertions.sv ***
module tsc_assertions
  import tsc_pkg::*;
(
  input wire logic         pclk,
  input wire logic         presetn,
  input wire logic         left_turn_in,
  input wire logic         right_turn_in,
  input wire logic         brake_in,
  input wire logic         emergency_in,
  input wire logic         parking_in,
  input wire tsc_lamp_type lamps,
  input wire logic         irq
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========
  // lamp checks
  // a lamp follows its pins three clocks later
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire lsig = left_turn_in | emergency_in;
  wire rsig = right_turn_in | emergency_in;
  chk_reset_dark: assert property ($rose(presetn) |-> lamps == '0 && !irq)
    else $error("lamp or irq on after reset");
  chk_ldash_src: assert property (lamps.left_dash |-> $past(lsig, 3))
    else $error("left dash without cause");
  chk_rdash_src: assert property (lamps.right_dash |-> $past(rsig, 3))
    else $error("right dash without cause");
  chk_front_src: assert property (lamps.left_front |-> $past(lsig | parking_in, 3))
    else $error("left front without cause");
  chk_rear_src: assert property (lamps.right_rear |-> $past(rsig | parking_in | brake_in, 3))
    else $error("right rear without cause");
  chk_brake_on: assert property ($past(presetn,3) && $past(brake_in & !left_turn_in,3)
    |-> lamps.left_rear) else $error("left rear not on for brake");
  chk_emerg_pair: assert property ($past(presetn,3) && $past(emergency_in,3)
    |-> lamps.left_dash == lamps.right_dash) else $error("hazard sides differ");
  chk_dash_lamps: assert property (lamps.left_dash |-> lamps.left_front && lamps.left_rear)
    else $error("left dash on without turn lamps");
endmodule
bind tsc_top tsc_assertions u_chk (.pclk(pclk), .presetn(presetn), .left_turn_in(left_turn_in),
  .right_turn_in(right_turn_in), .brake_in(brake_in), .emergency_in(emergency_in),
  .parking_in(parking_in), .lamps(lamps), .irq(irq));

// *** dv/tsc_switch_model.sv ***
module tsc_switch_model
  import tsc_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic [1:0] lever,
  input  wire logic [2:0] aux,
  output tsc_switch_type  sw
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========
  // contacts
  // lever closes one contact of three, so at most one turn line is high
  initial sw = '0;
  always @(posedge pclk) begin
    sw <= {lever == 2'h1, lever == 2'h2, aux};
  end
endmodule

// *** dv/turn_signal_controller_tb.sv ***
module turn_signal_controller_tb
  import tsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========
  // bench
  logic           pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic           pready, pslverr, irq;
  logic [11:0]    paddr = '0;
  logic [31:0]    pwdata = '0, prdata, q;
  logic [1:0]     lever = '0;
  logic [2:0]     aux = '0;
  logic [7:0]     sd [4] = '{8'h80, 8'h00, 8'h01, 8'h81};
  tsc_switch_type sw;
  tsc_lamp_type   lamps;
  logic [5:0]     le;
  int             n_mismatch = 0, cmp_count = 0;
  initial forever #25 pclk = ~pclk;
  tsc_top DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .left_turn_in(sw.left_turn), .right_turn_in(sw.right_turn), .brake_in(sw.brake),
    .emergency_in(sw.emergency), .parking_in(sw.parking), .lamps(lamps), .irq(irq));
  tsc_switch_model u_sw (.pclk(pclk), .lever(lever), .aux(aux), .sw(sw));
  // ==========
  // tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("unexpected %s exp %h got %h", nm, e, g);
      n_mismatch++;
    end
  endtask
  // one transfer held until pready; data and error taken at that edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    {q, err} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
  endtask
  task automatic rd(input logic [11:0] a, input string nm, input logic [31:0] e);
    apb(1'b0, a, '0);
    chk(nm, e, q);
  endtask
  // load the timer, then poll until it has counted once
  task automatic step(input logic [15:0] t);
    apb(1'b1, 12'h010, {16'h0, t});
    do apb(1'b0, 12'h010, '0); while (q[15:0] === t);
  endtask
  // lamps from lever row i and subdivider value s
  function automatic logic [5:0] lamp_exp(input int i, input logic [7:0] s);
    logic lt, rt, br, em, dim, ld, rdh;
    lt = i % 3 == 1;
    rt = i % 3 == 2;
    {br, em, dim} = 3'(i / 3);
    dim = dim & s[0];
    ld = (lt | em) & s[7];
    rdh = (rt | em) & s[7];
    return {ld | dim, rdh | dim, ld | br & !lt | dim, rdh | br & !rt | dim, ld, rdh};
  endfunction
  task automatic stop_test;
    $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ==========
  // tests
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    chk("lamps", 32'h0, {26'h0, lamps});
    rd(12'h000, "ctrl", 32'h0);
    rd(12'h010, "timer", 32'h0);
    rd(12'h014, "subdiv", 32'hf4);
    rd(12'h004, "status", 32'h2);
    rd(12'h020, "unmapped", 32'h0);
    chk("pslverr", 32'h1, {31'h0, err});
    apb(1'b1, 12'h00c, 32'h1);
    apb(1'b1, 12'h000, 32'h17);
    step(16'h00ff);
    chk("timer", 32'h0100, q);
    step(16'hffff);
    chk("timer", 32'hf000, q);
    rd(12'h014, "subdiv", 32'hf3);
    chk("irq", 32'h1, {31'h0, irq});
    rd(12'h008, "stat", 32'h1);
    @(posedge pclk);
    chk("irq", 32'h0, {31'h0, irq});
    apb(1'b1, 12'h014, 32'h1);
    step(16'hffff);
    rd(12'h014, "subdiv", 32'hf4);
    apb(1'b1, 12'h00c, 32'h0);
    rd(12'h008, "stat", 32'h3);
    apb(1'b1, 12'h000, 32'h11);
    step(16'hffff);
    rd(12'h008, "stat", 32'h0);
    apb(1'b1, 12'h000, 32'h17);
    step(16'hffff);
    chk("irq", 32'h0, {31'h0, irq});
    rd(12'h008, "stat", 32'h1);
    apb(1'b1, 12'h000, 32'h07);
    apb(1'b1, 12'h010, 32'h00ff);
    repeat (50) @(posedge pclk);
    rd(12'h010, "timer", 32'h00ff);
    apb(1'b1, 12'h000, 32'h0);
    foreach (sd[k]) begin
      apb(1'b1, 12'h014, {24'h0, sd[k]});
      for (int i = 0; i < 24; i++) begin
        lever <= 2'(i % 3);
        aux <= 3'(i / 3);
        repeat (6) @(posedge pclk);
        le = lamp_exp(i, sd[k]);
        chk("lamps", {26'h0, le}, {26'h0, lamps});
        rd(12'h004, "status", {26'h0, le[1:0], i % 3 == 1, i % 3 == 2, sd[k][7], sd[k][0]});
      end
    end
    stop_test();
  end
  // watchdog
  initial begin
    #1000000;
    n_mismatch++;
    stop_test();
  end
endmodule

// *** include/tsc_params.svh ***
`ifndef TSC_PARAMS_SVH
`define TSC_PARAMS_SVH
// Function
// - active turn or emergency gates slow blink to dashboard and turn lamps
// - emergency blinks all six lamps with the slow blink signal
// - brake holds rear lamps steady except the side turning, which blinks
// - brake leaves front and dashboard lamps untouched
// - parking adds fast modulation to front and rear lamps, not dashboard
// - lamp outputs follow the brake, emergency and turn truth table
// - low timer byte counts each machine cycle, overflow bumps high byte
// - high byte overflow raises a tick when events are enabled
// - each tick reloads high byte with -16, tick every 4.096 ms
// - 8-bit subdivider decrements per tick, reloads 244 when the tick arrives at one
// - subdivider bit 0 is fast modulation, bit 7 slow blink
// - lamps re-evaluated often enough that parking lights do not flicker

// =====================================================================
// register map
`define TSC_CTRL_ADDR       12'h000
`define TSC_STATUS_ADDR     12'h004
`define TSC_IRQ_STAT_ADDR   12'h008
`define TSC_IRQ_MASK_ADDR   12'h00c
`define TSC_TIMER_ADDR      12'h010
`define TSC_SUBDIV_ADDR     12'h014
// control fields
`define TSC_CTRL_RUN_BIT    0
`define TSC_CTRL_TEV_BIT    1
`define TSC_CTRL_GEV_BIT    2
`define TSC_CTRL_MODE_LSB   4
// interrupt status fields
`define TSC_IRQ_TICK_BIT    0
`define TSC_IRQ_BLINK_BIT   1
// reset, reload and mode values
`define TSC_CTRL_RESET      8'h00
`define TSC_TH_RESET        8'h00
`define TSC_IRQ_RESET       2'h0
`define TSC_MODE_16BIT      2'h1
`define TSC_TH_RELOAD       8'hf0
`define TSC_TL_RESET        8'h00
`define TSC_SUBDIV_RELOAD   8'hf4
// timing: one machine cycle is 1 us at this clock
`define TSC_MACHINE_CYCLE_NS 1000
`define TSC_CLK_PERIOD_NS    50
`define TSC_CYC_PER_MC ((`TSC_MACHINE_CYCLE_NS + `TSC_CLK_PERIOD_NS - 1) / `TSC_CLK_PERIOD_NS)
`endif

// *** include/tsc_pkg.sv ***
package tsc_pkg;
  // switch inputs grouped
  typedef struct packed {
    logic left_turn;
    logic right_turn;
    logic brake;
    logic emergency;
    logic parking;
  } tsc_switch_type;
  // lamp outputs grouped
  typedef struct packed {
    logic left_front;
    logic right_front;
    logic left_rear;
    logic right_rear;
    logic left_dash;
    logic right_dash;
  } tsc_lamp_type;
endpackage
